// ==== csr_cpu_stack_reset_unit.sv ====
// Stack pointers, operand addressing and reset sequencing of the CPU core.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "csr_params.svh"

// Contract
// - Any reset clears program stack pointer; stack grows upward.
// - Load program stack pointer from accumulator; firmware cannot read it back.
// - Interrupt acknowledge disables interrupts, stores two bytes, pointer plus two.
// - Interrupt return pops second then first byte, restores flags, re-enables.
// - Call stores program counter and flags; pointer ends two higher.
// - Subroutine return restores program counter only; pointer two lower.
// - Push pre-decrements data stack pointer, then writes byte.
// - Pop reads byte at data stack pointer, then increments.
// - Data stack pointer resets to zero; push at zero writes address FF.
// - Accumulator and data stack pointer can be exchanged.
// - Data memory is 256 bytes with 8-bit addresses.
// - Immediate mode takes operand from instruction second byte.
// - Direct mode uses instruction byte as RAM address.
// - Indexed mode adds instruction byte to index register.
// - Resets restore defaults, clear USB address, interrupts, both pointers.
// - Cause register bit 4 records power-on, bit 6 records watchdog.
// - After reset execution starts at zero with nothing pushed.
// - CPU halted during power-on reset and semi-suspend.
// - After power-on: 1 ms uninterruptible, then 95 ms semi-suspend.
// - USB bus reset during semi-suspend starts execution immediately.
// - Early bus reset stays pending until enable bit and global enable.
// - Watchdog reset holds 2 ms, then executes from zero.
module csr_cpu_stack_reset_unit (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic por_in,
  input wire logic wdt_expire,
  input wire logic usb_bus_reset,
  input wire csr_pkg::csr_op_type op,
  input wire logic op_valid,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] push_data,
  input wire logic [13:0] pc_in,
  input wire logic carry_in,
  input wire logic zero_in,
  input wire csr_pkg::csr_amode_type amode,
  input wire logic [7:0] instr_byte,
  input wire logic [7:0] index_in,
  input wire logic [7:0] ram_rdata,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ram_we,
  output logic [7:0] operand,
  output logic [7:0] acc_out,
  output logic acc_load,
  output logic [13:0] pc_out,
  output logic pc_load,
  output logic carry_out,
  output logic zero_out,
  output logic flags_load,
  output logic cpu_run,
  output logic int_enable,
  output logic bus_reset_irq,
  output logic [6:0] usb_addr_clear,
  output logic busy
);
  import csr_pkg::*;

  csr_state_type state_ff, nxt_state;
  logic [31:0] cnt_ff;
  logic [7:0] psp_ff;
  logic [7:0] dsp_ff;
  logic [7:0] cause_ff;
  logic ctrl_usbie_ff, ctrl_gie_ff;
  logic busrst_pend_ff;
  logic [2:0] por_sync_ff, wdt_sync_ff, usb_sync_ff;
  logic por_s, wdt_s, usb_s;
  logic [2:0] step_ff;
  csr_op_type cur_ff;
  logic [7:0] hi_ff;
  logic apb_acc;
  logic soft_rst;

  function automatic logic [7:0] wrap_add(input logic [7:0] a, input logic [7:0] b);
    wrap_add = a + b;
  endfunction

  assign por_s = por_sync_ff[1];
  assign wdt_s = wdt_sync_ff[1];
  assign usb_s = usb_sync_ff[1];
  assign apb_acc = psel & penable;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      por_sync_ff <= 3'h0;
      wdt_sync_ff <= 3'h0;
      usb_sync_ff <= 3'h0;
    end else begin
      por_sync_ff <= {por_sync_ff[1], por_sync_ff[0], por_in};
      wdt_sync_ff <= {wdt_sync_ff[1], wdt_sync_ff[0], wdt_expire};
      usb_sync_ff <= {usb_sync_ff[1], usb_sync_ff[0], usb_bus_reset};
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CSR_POR: if (!por_s) nxt_state = CSR_HOLD;
      CSR_HOLD: if (cnt_ff >= `CSR_HOLD_CYC - 1) nxt_state = CSR_SEMI;
      CSR_SEMI: if (usb_s || cnt_ff >= `CSR_SEMI_CYC - 1) nxt_state = CSR_RUN;
      CSR_RUN: nxt_state = CSR_RUN;
      CSR_WDOG: if (cnt_ff >= `CSR_WDR_CYC - 1) nxt_state = CSR_RUN;
      default: nxt_state = CSR_POR;
    endcase
    if (por_s) nxt_state = CSR_POR;
    else if (wdt_s && state_ff != CSR_WDOG) nxt_state = CSR_WDOG;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= CSR_POR;
      cnt_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= (nxt_state != state_ff) ? 32'h0 : cnt_ff + 32'h1;
    end
  end

  assign soft_rst = (state_ff != CSR_RUN);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // Leaving reset_n is a power-up, so the power-on cause bit starts set.
      cause_ff <= `CSR_CAUSE_POR;
    end else if (por_s) begin
      cause_ff <= `CSR_ZERO8;
      cause_ff[`CSR_POR_BIT] <= 1'b1;
    end else if (wdt_s && state_ff != CSR_WDOG) begin
      cause_ff[`CSR_WDR_BIT] <= 1'b1;
    end else if (psel && penable && pwrite && paddr == `CSR_ADDR_CAUSE) begin
      cause_ff <= pwdata[7:0] & cause_ff;
    end
  end

  // Control bits cleared by either reset.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_usbie_ff <= 1'b0;
      ctrl_gie_ff <= 1'b0;
    end else if (soft_rst) begin
      ctrl_usbie_ff <= 1'b0;
      ctrl_gie_ff <= 1'b0;
    end else if (apb_acc && pwrite && paddr == `CSR_ADDR_CTRL) begin
      ctrl_usbie_ff <= pwdata[`CSR_CTRL_USBIE];
      ctrl_gie_ff <= pwdata[`CSR_CTRL_GIE];
    end else if (op_valid && step_ff == 3'h0 && op == CSR_OP_IACK) begin
      ctrl_gie_ff <= 1'b0;
    end else if (cur_ff == CSR_OP_RETURN_FROM_INTERRUPT && step_ff == 3'h3) begin
      ctrl_gie_ff <= 1'b1;
    end
  end

  // Bus reset held pending; set wins over clear.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busrst_pend_ff <= 1'b0;
    end else if (state_ff == CSR_SEMI && usb_s) begin
      busrst_pend_ff <= 1'b1;
    end else if (bus_reset_irq) begin
      busrst_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_reset_irq <= 1'b0;
    end else begin
      bus_reset_irq <= busrst_pend_ff & ctrl_usbie_ff & ctrl_gie_ff & ~bus_reset_irq;
    end
  end

  // Stack sequencer: two RAM steps per program stack operation.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_ff <= 3'h0;
      cur_ff <= CSR_OP_NONE;
    end else if (soft_rst) begin
      step_ff <= 3'h0;
      cur_ff <= CSR_OP_NONE;
    end else if (step_ff == 3'h0) begin
      if (op_valid && (op == CSR_OP_IACK || op == CSR_OP_CALL
                       || op == CSR_OP_RETURN_FROM_INTERRUPT || op == CSR_OP_RET || op == CSR_OP_POP)) begin
        step_ff <= 3'h1;
        cur_ff <= op;
      end
    end else if (cur_ff == CSR_OP_POP || step_ff == 3'h3) begin
      step_ff <= 3'h0;
      cur_ff <= CSR_OP_NONE;
    end else begin
      step_ff <= step_ff + 3'h1;
    end
  end

  // Program stack pointer with modulo wrap.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      psp_ff <= `CSR_ZERO8;
    end else if (soft_rst) begin
      psp_ff <= `CSR_ZERO8;
    end else if (step_ff == 3'h0 && op_valid && op == CSR_OP_LDPSP) begin
      psp_ff <= acc_in;
    end else if ((cur_ff == CSR_OP_IACK || cur_ff == CSR_OP_CALL)
                 && (step_ff == 3'h1 || step_ff == 3'h2)) begin
      psp_ff <= wrap_add(psp_ff, `CSR_ONE8);
    end else if ((cur_ff == CSR_OP_RETURN_FROM_INTERRUPT || cur_ff == CSR_OP_RET)
                 && (step_ff == 3'h1 || step_ff == 3'h2)) begin
      psp_ff <= wrap_add(psp_ff, 8'hFF);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dsp_ff <= `CSR_ZERO8;
    end else if (soft_rst) begin
      dsp_ff <= `CSR_ZERO8;
    end else if (step_ff == 3'h0 && op_valid && op == CSR_OP_PUSH) begin
      dsp_ff <= wrap_add(dsp_ff, 8'hFF);
    end else if (step_ff == 3'h0 && op_valid && op == CSR_OP_SWPDSP) begin
      dsp_ff <= acc_in;
    end else if (cur_ff == CSR_OP_POP && step_ff == 3'h1) begin
      dsp_ff <= wrap_add(dsp_ff, `CSR_ONE8);
    end
  end

  // RAM port and results. 8-bit addresses.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_addr <= `CSR_ZERO8;
      ram_wdata <= `CSR_ZERO8;
      ram_we <= 1'b0;
    end else begin
      ram_we <= 1'b0;
      if (!soft_rst && step_ff == 3'h0 && op_valid && op == CSR_OP_PUSH) begin
        ram_addr <= wrap_add(dsp_ff, 8'hFF);
        ram_wdata <= push_data;
        ram_we <= 1'b1;
      end else if (!soft_rst && step_ff == 3'h0 && op_valid && op == CSR_OP_POP) begin
        ram_addr <= dsp_ff;
      end else if ((cur_ff == CSR_OP_IACK || cur_ff == CSR_OP_CALL) && step_ff == 3'h1) begin
        // First byte: flags and upper PC.
        ram_addr <= psp_ff;
        ram_wdata <= {carry_in, zero_in, pc_in[13:8]};
        ram_we <= 1'b1;
      end else if ((cur_ff == CSR_OP_IACK || cur_ff == CSR_OP_CALL) && step_ff == 3'h2) begin
        ram_addr <= psp_ff;
        ram_wdata <= pc_in[7:0];
        ram_we <= 1'b1;
      end else if ((cur_ff == CSR_OP_RETURN_FROM_INTERRUPT || cur_ff == CSR_OP_RET)
                   && (step_ff == 3'h1 || step_ff == 3'h2)) begin
        ram_addr <= wrap_add(psp_ff, 8'hFF);
      end else if (amode == CSR_AM_DIR) begin
        ram_addr <= instr_byte;
      end else if (amode == CSR_AM_IDX) begin
        ram_addr <= wrap_add(instr_byte, index_in);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      operand <= `CSR_ZERO8;
    end else begin
      operand <= (amode == CSR_AM_IMM) ? instr_byte : ram_rdata;
    end
  end

  // Restore path: low byte read at step 2, high byte with flags at step 3.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_ff <= `CSR_ZERO8;
      pc_out <= `CSR_PC_RST;
      pc_load <= 1'b0;
      carry_out <= 1'b0;
      zero_out <= 1'b0;
      flags_load <= 1'b0;
      acc_out <= `CSR_ZERO8;
      acc_load <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      flags_load <= 1'b0;
      acc_load <= 1'b0;
      if (soft_rst) begin
        pc_out <= `CSR_PC_RST;
        pc_load <= 1'b1;
      end else if ((cur_ff == CSR_OP_RETURN_FROM_INTERRUPT || cur_ff == CSR_OP_RET) && step_ff == 3'h2) begin
        hi_ff <= ram_rdata;
      end else if ((cur_ff == CSR_OP_RETURN_FROM_INTERRUPT || cur_ff == CSR_OP_RET) && step_ff == 3'h3) begin
        pc_out <= {ram_rdata[5:0], hi_ff};
        pc_load <= 1'b1;
        if (cur_ff == CSR_OP_RETURN_FROM_INTERRUPT) begin
          carry_out <= ram_rdata[7];
          zero_out <= ram_rdata[6];
          flags_load <= 1'b1;
        end
      end else if (cur_ff == CSR_OP_POP && step_ff == 3'h1) begin
        acc_out <= ram_rdata;
        acc_load <= 1'b1;
      end else if (step_ff == 3'h0 && op_valid && op == CSR_OP_SWPDSP) begin
        acc_out <= dsp_ff;
        acc_load <= 1'b1;
      end
    end
  end

  // Status outputs and APB slave, one wait-free access cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_run <= 1'b0;
      int_enable <= 1'b0;
      usb_addr_clear <= 7'h7F;
      busy <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cpu_run <= ~soft_rst;
      int_enable <= ctrl_gie_ff & ~soft_rst;
      // USB address held clear during reset.
      usb_addr_clear <= {7{soft_rst}};
      busy <= (step_ff != 3'h0);
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel && !penable) begin
        case (paddr)
          `CSR_ADDR_CTRL: prdata <= {30'h0, ctrl_gie_ff, ctrl_usbie_ff};
          `CSR_ADDR_STAT: prdata <= {29'h0, state_ff};
          `CSR_ADDR_CAUSE: prdata <= {24'h0, cause_ff};
          `CSR_ADDR_PSP: prdata <= 32'h0;
          `CSR_ADDR_DSP: prdata <= {24'h0, dsp_ff};
          `CSR_ADDR_BUSRST: prdata <= {31'h0, busrst_pend_ff};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Push at zero lands at top.
  a_push_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    (!soft_rst && step_ff == 3'h0 && op_valid && op == CSR_OP_PUSH && dsp_ff == 8'h00)
    |=> (ram_addr == 8'hFF && ram_we && dsp_ff == 8'hFF)) else $error("push wrap wrong");
  a_call_plus2: assert property (@(posedge clk) disable iff (!reset_n || soft_rst)
    (step_ff == 3'h0 && op_valid && op == CSR_OP_CALL)
    |=> ##2 (psp_ff == $past(psp_ff, 3) + 8'h02)) else $error("call pointer wrong");
  a_ret_minus2: assert property (@(posedge clk) disable iff (!reset_n || soft_rst)
    (step_ff == 3'h0 && op_valid && op == CSR_OP_RET)
    |=> ##2 (psp_ff == $past(psp_ff, 3) - 8'h02)) else $error("ret pointer wrong");
  a_ret_flags: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_ff == CSR_OP_RET) |=> !flags_load) else $error("ret loaded flags");
  a_iack_di: assert property (@(posedge clk) disable iff (!reset_n || soft_rst)
    (step_ff == 3'h0 && op_valid && op == CSR_OP_IACK) |=> !ctrl_gie_ff)
    else $error("ack kept interrupts");
  a_halt_semi: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == CSR_SEMI || state_ff == CSR_HOLD) |=> !cpu_run) else $error("cpu ran");
  a_bypass_run: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == CSR_SEMI && usb_s && !por_s && !wdt_s) |=> ##1 cpu_run)
    else $error("no bypass");
  a_hold_nobypass: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == CSR_HOLD && !por_s && !wdt_s && cnt_ff < `CSR_HOLD_CYC - 1)
    |=> state_ff == CSR_HOLD) else $error("hold interrupted");
  a_reset_pc: assert property (@(posedge clk) disable iff (!reset_n)
    soft_rst |=> (pc_out == 14'h0000 && pc_load && !ram_we)) else $error("reset pc");
  c_push: cover property (@(posedge clk) disable iff (!reset_n) ram_we && cur_ff == CSR_OP_NONE);
  c_return_from_interrupt: cover property (@(posedge clk) disable iff (!reset_n) flags_load);
  c_bypass: cover property (@(posedge clk) disable iff (!reset_n) state_ff == CSR_SEMI && usb_s);
  c_irq: cover property (@(posedge clk) disable iff (!reset_n) bus_reset_irq);
endmodule // csr_cpu_stack_reset_unit

// ==== csr_params.svh ====
// Constants for the stack, addressing and reset sequencing unit.
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH
`define CSR_CLK_KHZ 100000
`define CSR_HOLD_MS 1
`define CSR_SEMI_MS 95
`define CSR_WDR_MS 2
`define CSR_HOLD_CYC (`CSR_HOLD_MS * `CSR_CLK_KHZ)
`define CSR_SEMI_CYC (`CSR_SEMI_MS * `CSR_CLK_KHZ)
`define CSR_WDR_CYC (`CSR_WDR_MS * `CSR_CLK_KHZ)
`define CSR_ZERO8 8'h00
`define CSR_ONE8 8'h01
`define CSR_PC_RST 14'h0000
`define CSR_POR_BIT 4
`define CSR_WDR_BIT 6
`define CSR_CAUSE_POR 8'h10
`define CSR_ADDR_CTRL 12'h000
`define CSR_ADDR_STAT 12'h004
`define CSR_ADDR_CAUSE 12'h008
`define CSR_ADDR_PSP 12'h00C
`define CSR_ADDR_DSP 12'h010
`define CSR_ADDR_BUSRST 12'h014
`define CSR_CTRL_USBIE 0
`define CSR_CTRL_GIE 1
`endif

// ==== csr_pkg.sv ====
// Types for the stack, addressing and reset sequencing unit.
package csr_pkg;
  typedef enum logic [2:0] {
    CSR_POR = 3'b000,
    CSR_HOLD = 3'b001,
    CSR_SEMI = 3'b011,
    CSR_RUN = 3'b010,
    CSR_WDOG = 3'b110
  } csr_state_type;
  typedef enum logic [1:0] {
    CSR_AM_IMM = 2'h0,
    CSR_AM_DIR = 2'h1,
    CSR_AM_IDX = 2'h2
  } csr_amode_type;
  typedef enum logic [3:0] {
    CSR_OP_NONE = 4'h0,
    CSR_OP_IACK = 4'h1,
    CSR_OP_CALL = 4'h2,
    CSR_OP_RETURN_FROM_INTERRUPT = 4'h3,
    CSR_OP_RET = 4'h4,
    CSR_OP_PUSH = 4'h5,
    CSR_OP_POP = 4'h6,
    CSR_OP_LDPSP = 4'h7,
    CSR_OP_SWPDSP = 4'h8
  } csr_op_type;
endpackage

// ==== csr_ram_model.sv ====
// Behavioural 256-byte data memory that sits on the far side of the unit.
`timescale 1ns/1ps
module csr_ram_model (
  input wire logic clk,
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_we,
  output logic [7:0] ram_rdata
);
  logic [7:0] mem [0:255];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
  end
  always @(posedge clk) begin
    if (ram_we === 1'b1) begin
      mem[ram_addr] <= ram_wdata;
    end
  end
  // Reads are asynchronous, so the unit sees the byte in the same cycle.
  assign ram_rdata = mem[ram_addr];
endmodule // csr_ram_model

// ==== test_cpu_stack_reset_unit.sv ====
// Self-checking bench for the stack, addressing and reset sequencing unit.
`timescale 1ns/1ps
`include "csr_params.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module test_cpu_stack_reset_unit;
  import csr_pkg::*;
  logic clk, reset_n, por_in, wdt_expire, usb_bus_reset, op_valid, carry_in, zero_in;
  csr_op_type op;
  csr_amode_type amode;
  logic [7:0] acc_in, push_data, instr_byte, index_in, ram_rdata, ram_addr, ram_wdata;
  logic [7:0] operand, acc_out, got_acc;
  logic [13:0] pc_in, pc_out, got_pc;
  logic psel, penable, pwrite, pready, pslverr, ram_we, acc_load, pc_load, carry_out;
  logic zero_out, flags_load, cpu_run, int_enable, bus_reset_irq, busy, err, got_c, got_z;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] usb_addr_clear;
  int n_fail, comparisons, n_flags, n_irq, k, saved;

  csr_cpu_stack_reset_unit u_csr_cpu_stack_reset_unit (
    .clk(clk), .reset_n(reset_n), .por_in(por_in), .wdt_expire(wdt_expire),
    .usb_bus_reset(usb_bus_reset), .op(op), .op_valid(op_valid), .acc_in(acc_in),
    .push_data(push_data), .pc_in(pc_in), .carry_in(carry_in), .zero_in(zero_in),
    .amode(amode), .instr_byte(instr_byte), .index_in(index_in), .ram_rdata(ram_rdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_we(ram_we), .operand(operand), .acc_out(acc_out),
    .acc_load(acc_load), .pc_out(pc_out), .pc_load(pc_load), .carry_out(carry_out),
    .zero_out(zero_out), .flags_load(flags_load), .cpu_run(cpu_run),
    .int_enable(int_enable), .bus_reset_irq(bus_reset_irq),
    .usb_addr_clear(usb_addr_clear), .busy(busy));
  csr_ram_model u_csr_ram_model (.clk(clk), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_rdata(ram_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulsed results are captured here so that tests may look at them later.
  always @(posedge clk) begin
    if (pc_load === 1'b1) got_pc <= pc_out;
    if (acc_load === 1'b1) got_acc <= acc_out;
    if (flags_load === 1'b1) begin
      got_c <= carry_out;
      got_z <= zero_out;
      n_flags <= n_flags + 1;
    end
    if (bus_reset_irq === 1'b1) n_irq <= n_irq + 1;
  end

  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
        @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  task chk_reg(input logic [11:0] a, input logic [31:0] e, input string nm);
    begin
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
    end
  endtask

  task op_run(input csr_op_type o, input logic [7:0] a, input logic [13:0] p,
              input logic c, input logic z);
    begin
      @(posedge clk);
      op <= o;
      op_valid <= 1'b1;
      acc_in <= a;
      push_data <= a;
      pc_in <= p;
      carry_in <= c;
      zero_in <= z;
      @(posedge clk);
      op_valid <= 1'b0;
      repeat (2) @(posedge clk);
      while (busy !== 1'b0) begin
        @(posedge clk);
      end
      repeat (4) @(posedge clk);
    end
  endtask

  task addr_chk(input csr_amode_type m, input logic [7:0] ib, input logic [7:0] ix,
                input logic [7:0] e);
    begin
      amode <= m;
      instr_byte <= ib;
      index_in <= ix;
      repeat (4) @(posedge clk);
      `CHK("operand", e, operand)
    end
  endtask

  initial begin
    #2000000;
    n_fail++;
    summarize();
  end

  initial begin
    {reset_n, por_in, wdt_expire, usb_bus_reset, op_valid, carry_in, zero_in} = '0;
    {psel, penable, pwrite, paddr, pwdata, pc_in} = '0;
    {acc_in, push_data, instr_byte, index_in} = '0;
    op = CSR_OP_NONE;
    amode = CSR_AM_IMM;
    {n_fail, comparisons, n_flags, n_irq} = '0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (95000) @(posedge clk);
    usb_bus_reset <= 1'b1;
    repeat (4990) @(posedge clk);
    `CHK("cpu_run in hold", 1'b0, cpu_run)
    for (k = 0; k < 300 && cpu_run !== 1'b1; k++) @(posedge clk);
    `CHK("cpu_run bypass", 1'b1, cpu_run)
    usb_bus_reset <= 1'b0;
    `CHK("boot pc", `CSR_PC_RST, got_pc)
    `CHK("boot no push", 8'hA5, u_csr_ram_model.mem[0])
    `CHK("usb addr run", 7'h00, usb_addr_clear)
    $display("test boot done");
    chk_reg(`CSR_ADDR_CAUSE, 32'h0000_0010, "cause");
    chk_reg(`CSR_ADDR_STAT, 32'(CSR_RUN), "state run");
    apb(1'b1, `CSR_ADDR_CAUSE, 32'h0);
    chk_reg(`CSR_ADDR_CAUSE, 32'h0, "cause clear");
    chk_reg(`CSR_ADDR_DSP, 32'h0, "dsp");
    chk_reg(`CSR_ADDR_BUSRST, 32'h1, "pending");
    apb(1'b0, 12'h0FC, 32'h0);
    `CHK("slverr", 1'b1, err)
    apb(1'b1, `CSR_ADDR_CTRL, 32'h2);
    `CHK("gie", 1'b1, int_enable)
    `CHK("irq early", 0, n_irq)
    apb(1'b1, `CSR_ADDR_CTRL, 32'h3);
    @(posedge clk);
    `CHK("irq", 1, n_irq)
    chk_reg(`CSR_ADDR_BUSRST, 32'h0, "serviced");
    $display("test registers done");
    op_run(CSR_OP_PUSH, 8'h3C, 14'h0, 1'b0, 1'b0);
    `CHK("push top", 8'h3C, u_csr_ram_model.mem[255])
    op_run(CSR_OP_PUSH, 8'h4D, 14'h0, 1'b0, 1'b0);
    `CHK("push next", 8'h4D, u_csr_ram_model.mem[254])
    chk_reg(`CSR_ADDR_DSP, 32'hFE, "dsp");
    op_run(CSR_OP_POP, 8'h0, 14'h0, 1'b0, 1'b0);
    `CHK("pop one", 8'h4D, got_acc)
    op_run(CSR_OP_POP, 8'h0, 14'h0, 1'b0, 1'b0);
    `CHK("pop two", 8'h3C, got_acc)
    chk_reg(`CSR_ADDR_DSP, 32'h0, "dsp wrap");
    $display("test data stack done");
    op_run(CSR_OP_CALL, 8'h0, 14'h1234, 1'b1, 1'b0);
    `CHK("call hi", 8'h92, u_csr_ram_model.mem[0])
    `CHK("call lo", 8'h34, u_csr_ram_model.mem[1])
    op_run(CSR_OP_IACK, 8'h0, 14'h0ABC, 1'b0, 1'b1);
    `CHK("iack hi", 8'h4A, u_csr_ram_model.mem[2])
    `CHK("iack lo", 8'hBC, u_csr_ram_model.mem[3])
    `CHK("iack gie", 1'b0, int_enable)
    op_run(CSR_OP_RETURN_FROM_INTERRUPT, 8'h0, 14'h0, 1'b1, 1'b0);
    `CHK("return_from_interrupt pc", 14'h0ABC, got_pc)
    `CHK("return_from_interrupt flags", 2'b01, {got_c, got_z})
    `CHK("return_from_interrupt gie", 1'b1, int_enable)
    saved = n_flags;
    op_run(CSR_OP_RET, 8'h0, 14'h0, 1'b0, 1'b1);
    `CHK("ret pc", 14'h1234, got_pc)
    `CHK("ret flags", saved, n_flags)
    op_run(CSR_OP_LDPSP, 8'hFE, 14'h0, 1'b0, 1'b0);
    op_run(CSR_OP_CALL, 8'h0, 14'h0155, 1'b0, 1'b0);
    `CHK("load hi", 8'h01, u_csr_ram_model.mem[254])
    `CHK("load lo", 8'h55, u_csr_ram_model.mem[255])
    op_run(CSR_OP_CALL, 8'h0, 14'h2001, 1'b1, 1'b1);
    `CHK("wrap hi", 8'hE0, u_csr_ram_model.mem[0])
    chk_reg(`CSR_ADDR_PSP, 32'h0, "psp hidden");
    op_run(CSR_OP_SWPDSP, 8'h20, 14'h0, 1'b0, 1'b0);
    `CHK("swap acc", 8'h00, got_acc)
    chk_reg(`CSR_ADDR_DSP, 32'h20, "swap dsp");
    $display("test program stack done");
    addr_chk(CSR_AM_IMM, 8'hD8, 8'h00, 8'hD8);
    addr_chk(CSR_AM_DIR, 8'h10, 8'h00, 8'h10 ^ 8'hA5);
    addr_chk(CSR_AM_IDX, 8'h10, 8'h03, 8'h13 ^ 8'hA5);
    addr_chk(CSR_AM_IDX, 8'hF0, 8'h20, 8'h10 ^ 8'hA5);
    $display("test addressing done");
    wdt_expire <= 1'b1;
    for (k = 0; k < 50 && cpu_run !== 1'b0; k++) @(posedge clk);
    `CHK("wdr halt", 1'b0, cpu_run)
    `CHK("wdr gie", 1'b0, int_enable)
    `CHK("wdr usb addr", 7'h7F, usb_addr_clear)
    chk_reg(`CSR_ADDR_STAT, 32'(CSR_WDOG), "wdr state");
    apb(1'b0, `CSR_ADDR_CAUSE, 32'h0);
    `CHK("wdr cause", 1'b1, rd[`CSR_WDR_BIT])
    chk_reg(`CSR_ADDR_DSP, 32'h0, "wdr dsp");
    $display("test watchdog done");
    summarize();
  end
endmodule // test_cpu_stack_reset_unit
